//--- src/gpd_regs.sv
// Pin data, pin direction and diagnostic control register bank
`timescale 1ns/100ps
`include "gpd_cfg.svh"
module gpd_regs #(
  parameter int PINS = `GPD_PINS
) (
  // Clock and power-on reset
  input  wire logic                 mclk,
  input  wire logic                 reset,
  // Link reset and global reset pin, synchronous, active high
  input  wire logic                 link_reset,
  input  wire logic                 global_reset_pin,
  // Configuration access
  input  wire gpd_pkg::gpd_cfg_req_s cfg_req,
  output gpd_pkg::gpd_cfg_rsp_s     cfg_rsp,
  // General-purpose terminals
  input  wire logic [PINS-1:0]      pin_in,
  output logic      [PINS-1:0]      pin_out,
  output logic      [PINS-1:0]      pin_oe_n,
  // Secondary function enables from the owning blocks
  input  wire logic [PINS-1:0]      sec_enable,
  // Captured primary bus and device numbers
  input  wire logic                 capture_valid,
  input  wire logic [7:0]           bus_number_in,
  input  wire logic [4:0]           device_number_in,
  // Clock request from the power manager, active low
  input  wire logic                 clkreq_request_n,
  output logic                      clkreq_n,
  // Control outputs
  output gpd_pkg::gpd_diag_ctl_s    diag_ctl,
  output logic      [31:0]          diag_control_1
);
  import gpd_pkg::*;

  // Merge write data into a register under byte enables and a mask
  function automatic logic [31:0] be_merge(
    input logic [31:0] old_val,
    input logic [31:0] wdata,
    input logic [3:0]  be,
    input logic [31:0] wmask
  );
    logic [31:0] lanes;
    lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    be_merge = (old_val & ~(lanes & wmask)) | (wdata & lanes & wmask);
  endfunction : be_merge

  // Dword compare of an access address against a byte offset
  function automatic logic hit(
    input logic [7:0] addr,
    input logic [7:0] ofs
  );
    hit = (addr[7:2] == ofs[7:2]);
  endfunction : hit

  logic              soft_clear;
  logic [PINS-1:0]   pin_sync;
  logic [PINS-1:0]   pin_dir;
  logic [PINS-1:0]   pin_latch;
  logic [PINS-1:0]   sec_eff;
  logic [PINS-1:0]   gp_out_mode;
  logic [PINS-1:0]   pin_value;
  logic [31:0]       diag0;
  logic [31:0]       diag1;
  logic [31:0]       next_rdata;
  logic              wr_dir;
  logic              wr_diag0;
  logic              wr_diag1;
  logic [31:0]       dir_word;
  logic [31:0]       dir_merged;
  logic [7:0]        pin_byte;

  // Any of the three resets returns the bank to defaults
  assign soft_clear = link_reset | global_reset_pin;

  // Only terminals 0, 1, 3 and 4 have secondary functions
  assign sec_eff = sec_enable & PINS'(`GPD_SEC_CAPABLE);

  // Terminal driven by this bank: output mode and no secondary use
  assign gp_out_mode = pin_dir & ~sec_eff;

  // Input levels pass two flip-flops before use
  gpd_sync #(
    .W (PINS)
  ) u_sync (
    .mclk     (mclk),
    .reset    (reset),
    .async_in (pin_in),
    .sync_out (pin_sync)
  );

  // Write decode
  assign wr_dir   = cfg_req.valid & cfg_req.write &
                    hit(cfg_req.addr, `GPD_OFS_DIR);
  assign wr_diag0 = cfg_req.valid & cfg_req.write &
                    hit(cfg_req.addr, `GPD_OFS_DIAG0);
  assign wr_diag1 = cfg_req.valid & cfg_req.write &
                    hit(cfg_req.addr, `GPD_OFS_DIAG1);

  // Direction word merged under lane 0 enable only
  assign dir_word   = {{(32-PINS){1'b0}}, pin_dir};
  assign dir_merged = be_merge(dir_word, cfg_req.wdata, cfg_req.be,
                               {{(32-PINS){1'b0}}, {PINS{1'b1}}});

  // Direction register, all inputs after any reset
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pin_dir <= '0;
    end else if (soft_clear) begin
      pin_dir <= '0;
    end else if (wr_dir) begin
      pin_dir <= dir_merged[PINS-1:0];
    end
  end

  // Output data latch; writes land only on driven terminals
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pin_latch <= '0;
    end else if (soft_clear) begin
      pin_latch <= '0;
    end else if (wr_dir && cfg_req.be[`GPD_DATA_LANE]) begin
      for (int i = 0; i < PINS; i++) begin
        if (gp_out_mode[i]) begin
          pin_latch[i] <= cfg_req.wdata[`GPD_DATA_LSB + i];
        end
      end
    end
  end

  // Pin drivers: enable low while this bank drives the terminal
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pin_out  <= '0;
      pin_oe_n <= '1;
    end else if (soft_clear) begin
      pin_out  <= '0;
      pin_oe_n <= '1;
    end else begin
      pin_out  <= pin_latch;
      pin_oe_n <= ~gp_out_mode;
    end
  end

  // Read view: driven terminals show the latch, others the pin level
  always_comb begin
    pin_value = '0;
    for (int i = 0; i < PINS; i++) begin
      pin_value[i] = gp_out_mode[i] ? pin_latch[i] : pin_sync[i];
    end
    pin_byte = 8'h00;
    pin_byte[PINS-1:0] = pin_value;
  end

  // Diagnostic register 0: writable fields plus captured numbers
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      diag0 <= `GPD_DIAG0_RESET;
    end else if (soft_clear) begin
      diag0 <= `GPD_DIAG0_RESET;
    end else begin
      if (wr_diag0) begin
        diag0 <= be_merge(diag0, cfg_req.wdata, cfg_req.be,
                          `GPD_DIAG0_RW_MASK);
      end
      if (capture_valid) begin
        diag0[`GPD_BUS_MSB:`GPD_BUS_LSB] <= bus_number_in;
        diag0[`GPD_DEV_MSB:`GPD_DEV_LSB] <= device_number_in;
      end
    end
  end

  // Diagnostic register 1: stored and presented, fields used elsewhere
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      diag1 <= `GPD_DIAG1_RESET;
    end else if (soft_clear) begin
      diag1 <= `GPD_DIAG1_RESET;
    end else if (wr_diag1) begin
      diag1 <= be_merge(diag1, cfg_req.wdata, cfg_req.be,
                        `GPD_DIAG1_RW_MASK);
    end
  end

  // Control outputs taken from diagnostic registers 0 and 1
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      diag_ctl       <= '{advisory_error_select: 1'b0,
                          mem_cfg_access_enable: 1'b0,
                          clock_request_hold:    1'b1};
      clkreq_n       <= 1'b0;
      diag_control_1 <= `GPD_DIAG1_RESET;
    end else begin
      diag_ctl.advisory_error_select <= diag0[`GPD_ADV_ERR_BIT];
      diag_ctl.mem_cfg_access_enable <= diag0[`GPD_MEM_CFG_BIT];
      diag_ctl.clock_request_hold    <= diag0[`GPD_CLKREQ_BIT];
      // Hold forces the request low, else follow the power manager
      clkreq_n       <= clkreq_request_n & ~diag0[`GPD_CLKREQ_BIT];
      diag_control_1 <= diag1;
    end
  end

  // Read data mux; reserved and unmapped bits read zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (hit(cfg_req.addr, `GPD_OFS_DIR)) begin
      next_rdata[PINS-1:0] = pin_dir;
      next_rdata[`GPD_DATA_LSB +: 8] = pin_byte;
    end else if (hit(cfg_req.addr, `GPD_OFS_DIAG0)) begin
      next_rdata = diag0;
    end else if (hit(cfg_req.addr, `GPD_OFS_DIAG1)) begin
      next_rdata = diag1;
    end
  end

  // Read answer one cycle after each access, write or read
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cfg_rsp <= '0;
    end else begin
      cfg_rsp.valid <= cfg_req.valid;
      cfg_rsp.rdata <= (cfg_req.valid && !cfg_req.write) ?
                       next_rdata : 32'h0000_0000;
    end
  end

endmodule : gpd_regs

//--- src/gpd_cfg.svh
// Constants for the pin data and diagnostic control register bank
// Summary of operation
// - Input-mode pin data bits read pin level
// - Output-mode data bit write drives pin
// - Writes to input or secondary pins discarded
// - Secondary functions on terminals 0, 1, 3, 4
// - Pin data bits 15:5 read zero
// - After power-up all pins are inputs
// - Link, global or power-on reset restore defaults
// - Diag0 31:24 read-only captured bus number
// - Diag0 23:19 read-only captured device number
// - Bit 18 set disables advisory error reporting
// - Read-only reserved diag0 fields return zero
// - Bit 2 enables memory-mapped config access
// - Bit 0 holds clock request asserted, resets one
// - Direction bit zero input, one output
`ifndef GPD_CFG_SVH
`define GPD_CFG_SVH

// Configuration byte offsets
`define GPD_OFS_DIR        8'hB4
`define GPD_OFS_DATA       8'hB6
`define GPD_OFS_DIAG0      8'hC0
`define GPD_OFS_DIAG1      8'hC4

// Terminal count and secondary-capable terminals
`define GPD_PINS           5
`define GPD_SEC_CAPABLE    5'h1B

// Pin data sits in the upper half of the direction dword
`define GPD_DATA_LSB       16
`define GPD_DATA_LANE      2
`define GPD_DIR_LANE       0

// Diagnostic register 0 layout and reset
`define GPD_DIAG0_RESET    32'h0000_0001
`define GPD_DIAG0_RW_MASK  32'h0004_CF87
`define GPD_BUS_MSB        31
`define GPD_BUS_LSB        24
`define GPD_DEV_MSB        23
`define GPD_DEV_LSB        19
`define GPD_ADV_ERR_BIT    18
`define GPD_MEM_CFG_BIT    2
`define GPD_CLKREQ_BIT     0

// Diagnostic register 1 reset and writable bits
`define GPD_DIAG1_RESET    32'h0012_0108
`define GPD_DIAG1_RW_MASK  32'hFFFF_FFFF

`endif

//--- src/gpd_pkg.sv
// Types shared by the pin data and diagnostic register bank
package gpd_pkg;

  // One configuration access, taken in the cycle valid is high
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } gpd_cfg_req_s;

  // Read answer, one cycle after the access
  typedef struct packed {
    logic        valid;
    logic [31:0] rdata;
  } gpd_cfg_rsp_s;

  // Control bits steered by diagnostic register 0
  typedef struct packed {
    logic advisory_error_select;
    logic mem_cfg_access_enable;
    logic clock_request_hold;
  } gpd_diag_ctl_s;

  typedef logic [4:0] gpd_pins_t;

endpackage : gpd_pkg

//--- src/gpd_sync.sv
// Two-stage synchroniser for the terminal input levels
`timescale 1ns/100ps
module gpd_sync #(
  parameter int W = 5
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         reset,
  // Levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] stage1;

  // First stage feeds only the second stage
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule : gpd_sync

//--- dv/gpd_regs_props.sv
// Concurrent checks on the ports of the register bank
`timescale 1ns/100ps
module gpd_regs_props #(
  parameter int PINS = 5
) (
  // Clocks and resets
  input wire logic                  mclk,
  input wire logic                  reset,
  input wire logic                  link_reset,
  input wire logic                  global_reset_pin,
  // Access and pins
  input wire gpd_pkg::gpd_cfg_req_s cfg_req,
  input wire gpd_pkg::gpd_cfg_rsp_s cfg_rsp,
  input wire logic [PINS-1:0]       pin_in,
  input wire logic [PINS-1:0]       pin_out,
  input wire logic [PINS-1:0]       pin_oe_n,
  input wire logic [PINS-1:0]       sec_enable,
  // Capture, clock request and controls
  input wire logic                  capture_valid,
  input wire logic [7:0]            bus_number_in,
  input wire logic [4:0]            device_number_in,
  input wire logic                  clkreq_request_n,
  input wire logic                  clkreq_n,
  input wire gpd_pkg::gpd_diag_ctl_s diag_ctl,
  input wire logic [31:0]           diag_control_1
);
  import gpd_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // Decoded reads and any soft reset
  logic rst_any, rd_c0, rd_b4;
  assign rst_any = link_reset | global_reset_pin;
  assign rd_c0 = cfg_req.valid & ~cfg_req.write &
                 (cfg_req.addr[7:2] == 6'h30);
  assign rd_b4 = cfg_req.valid & ~cfg_req.write &
                 (cfg_req.addr[7:2] == 6'h2D);
  sequence s_held_reset;
    rst_any [*2];
  endsequence
  sequence s_cap_then_read;
    (capture_valid && !rst_any) ##1 (!capture_valid && !rst_any)
      ##1 (rd_c0 && !capture_valid && !rst_any);
  endsequence
  a_rsp_next: assert property (
    cfg_req.valid |=> cfg_rsp.valid)
    else $error("access not answered");
  a_idle_quiet: assert property (
    !cfg_req.valid |=> !cfg_rsp.valid)
    else $error("answer without access");
  a_write_zero: assert property (
    cfg_req.valid && cfg_req.write |=> cfg_rsp.rdata == 32'h0)
    else $error("write answer not zero");
  a_data_rsvd: assert property (
    rd_b4 |=> cfg_rsp.rdata[31:21] == 11'h0 &&
              cfg_rsp.rdata[15:5] == 11'h0)
    else $error("pin dword reserved bits set");
  a_diag_rsvd: assert property (
    rd_c0 |=> (cfg_rsp.rdata & 32'h0003_3078) == 32'h0)
    else $error("diag0 reserved bits set");
  a_capture_read: assert property (
    s_cap_then_read |=> cfg_rsp.rdata[31:19] ==
      {$past(bus_number_in, 3), $past(device_number_in, 3)})
    else $error("captured numbers wrong");
  a_clkreq_rel: assert property (
    clkreq_n == ($past(clkreq_request_n) &
                 !diag_ctl.clock_request_hold))
    else $error("clock request wrong");
  a_sec_undriven: assert property (
    (sec_enable & $past(sec_enable) & $past(sec_enable, 2) &
     5'h1B & ~pin_oe_n) == 5'h0)
    else $error("secondary pin driven");
  a_reset_outs: assert property (
    s_held_reset |=> pin_oe_n == {PINS{1'b1}} && pin_out == '0 &&
      diag_ctl == 3'b001 && diag_control_1 == 32'h0012_0108)
    else $error("soft reset defaults wrong");
endmodule : gpd_regs_props

bind gpd_regs gpd_regs_props #(.PINS(PINS)) u_props (
  .mclk(mclk), .reset(reset),
  .link_reset(link_reset), .global_reset_pin(global_reset_pin),
  .cfg_req(cfg_req), .cfg_rsp(cfg_rsp), .pin_in(pin_in), .pin_out(pin_out),
  .pin_oe_n(pin_oe_n), .sec_enable(sec_enable),
  .capture_valid(capture_valid),
  .bus_number_in(bus_number_in), .device_number_in(device_number_in),
  .clkreq_request_n(clkreq_request_n), .clkreq_n(clkreq_n),
  .diag_ctl(diag_ctl), .diag_control_1(diag_control_1));

//--- dv/tb_top.sv
// Self-checking bench for the register bank
`timescale 1ns/100ps
`include "gpd_cfg.svh"
module tb_top;
  import gpd_pkg::*;
  logic          mclk, reset, link_reset, global_reset_pin, capture_valid;
  logic          clkreq_request_n, clkreq_n;
  gpd_cfg_req_s  cfg_req;
  gpd_cfg_rsp_s  cfg_rsp;
  gpd_pins_t     pin_in, pin_out, pin_oe_n, sec_enable;
  logic [7:0]    bus_number_in;
  logic [4:0]    device_number_in;
  gpd_diag_ctl_s diag_ctl;
  logic [31:0]   diag_control_1, rd;
  int            errors, compares;

  gpd_regs #(.PINS(5)) dut (.mclk(mclk), .reset(reset),
    .link_reset(link_reset), .global_reset_pin(global_reset_pin),
    .cfg_req(cfg_req), .cfg_rsp(cfg_rsp), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .sec_enable(sec_enable),
    .capture_valid(capture_valid),
    .bus_number_in(bus_number_in), .device_number_in(device_number_in),
    .clkreq_request_n(clkreq_request_n), .clkreq_n(clkreq_n),
    .diag_ctl(diag_ctl), .diag_control_1(diag_control_1));

  // Clock at 125 MHz
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // One comparison
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // One access; answer stands in the cycle after the taking edge
  task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] be,
                     input logic [31:0] wd);
    @(posedge mclk);
    #1;
    cfg_req = '{1'b1, w, a, be, wd};
    @(posedge mclk);
    #1;
    cfg_req.valid = 1'b0;
    chk("answer valid", 32'h1, {31'h0, cfg_rsp.valid});
    rd = cfg_rsp.rdata;
  endtask : acc

  task automatic rchk(input string n, input logic [7:0] a,
                      input logic [31:0] e);
    acc(1'b0, a, 4'hF, 32'h0);
    chk(n, e, rd);
  endtask : rchk

  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask : cyc

  task automatic end_of_test;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test

  // Hang guard
  initial begin
    #400000;
    errors++;
    end_of_test();
  end

  // Main sequence
  initial begin
    errors = 0;
    compares = 0;
    reset = 1'b1;
    link_reset = 1'b0;
    global_reset_pin = 1'b0;
    capture_valid = 1'b0;
    clkreq_request_n = 1'b1;
    cfg_req = '0;
    pin_in = 5'h15;
    sec_enable = 5'h00;
    bus_number_in = 8'hA5;
    device_number_in = 5'h13;
    cyc(20);
    reset = 1'b0;
    rchk("diag0 reset", `GPD_OFS_DIAG0, 32'h0000_0001);
    rchk("diag1 reset", `GPD_OFS_DIAG1, 32'h0012_0108);
    rchk("pins reset", `GPD_OFS_DIR, 32'h0015_0000);
    chk("oe reset", 32'h1F, {27'h0, pin_oe_n});
    chk("clkreq reset", 32'h0, {31'h0, clkreq_n});
    chk("diag1 port reset", 32'h0012_0108, diag_control_1);
    rchk("unmapped", 8'hF0, 32'h0);
    $display("test defaults done");
    acc(1'b1, `GPD_OFS_DIAG0, 4'hF, 32'hFFFF_FFFF);
    rchk("diag0 ones", `GPD_OFS_DIAG0, 32'h0004_CF87);
    cyc(2);
    chk("ctl set", 32'h7, {29'h0, diag_ctl});
    chk("clkreq held", 32'h0, {31'h0, clkreq_n});
    acc(1'b1, `GPD_OFS_DIAG0, 4'h1, 32'h0);
    rchk("diag0 byte", `GPD_OFS_DIAG0, 32'h0004_CF00);
    cyc(2);
    chk("clkreq free", 32'h1, {31'h0, clkreq_n});
    chk("ctl low", 32'h4, {29'h0, diag_ctl});
    // Without the hold the request follows the power manager
    clkreq_request_n = 1'b0;
    cyc(2);
    chk("clkreq follows", 32'h0, {31'h0, clkreq_n});
    clkreq_request_n = 1'b1;
    acc(1'b1, `GPD_OFS_DIAG0, 4'hF, 32'h1);
    $display("test diag0 done");
    capture_valid = 1'b1;
    cyc(1);
    capture_valid = 1'b0;
    rchk("captured", `GPD_OFS_DIAG0, 32'hA598_0001);
    acc(1'b1, `GPD_OFS_DIAG0, 4'hF, 32'h1);
    rchk("capture kept", `GPD_OFS_DIAG0, 32'hA598_0001);
    $display("test capture done");
    acc(1'b1, `GPD_OFS_DIR, 4'h1, 32'h4);
    acc(1'b1, `GPD_OFS_DIR, 4'h4, 32'h0004_0000);
    cyc(2);
    chk("oe pin2", 32'h1B, {27'h0, pin_oe_n});
    chk("drive pin2", 32'h04, {27'h0, pin_out});
    pin_in = 5'h0A;
    sec_enable = 5'h05;
    acc(1'b1, `GPD_OFS_DIR, 4'h1, 32'h5);
    acc(1'b1, `GPD_OFS_DIR, 4'h4, 32'h001F_0000);
    cyc(3);
    chk("oe secondary", 32'h1B, {27'h0, pin_oe_n});
    chk("drive kept", 32'h04, {27'h0, pin_out});
    rchk("pins mixed", `GPD_OFS_DIR, 32'h000E_0005);
    sec_enable = 5'h00;
    $display("test pins done");
    for (int k = 0; k < 2; k++) begin
      acc(1'b1, `GPD_OFS_DIR, 4'h1, 32'h4);
      acc(1'b1, `GPD_OFS_DIAG1, 4'hF, 32'h0);
      cyc(1);
      chk("diag1 port", 32'h0, diag_control_1);
      link_reset = (k == 0);
      global_reset_pin = (k == 1);
      cyc(3);
      link_reset = 1'b0;
      global_reset_pin = 1'b0;
      cyc(1);
      chk("oe soft", 32'h1F, {27'h0, pin_oe_n});
      chk("drive soft", 32'h0, {27'h0, pin_out});
      chk("diag1 port soft", 32'h0012_0108, diag_control_1);
      rchk("diag1 soft", `GPD_OFS_DIAG1, 32'h0012_0108);
      rchk("diag0 soft", `GPD_OFS_DIAG0, 32'h0000_0001);
      rchk("pins soft", `GPD_OFS_DIR, 32'h000A_0000);
    end
    $display("test soft resets done");
    end_of_test();
  end
endmodule : tb_top
